// ===== fbm_pkg.sv
package fbm_pkg;
	localparam int PG_BYTES = 512;
	localparam int XFER_LEN = 515;
	localparam logic [9:0] MARK_COL = 10'h205;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam int SR_FAIL = 0;
	localparam int SR_RDY = 6;
	localparam logic [2:0] OP_READ = 3'h1;
	localparam logic [2:0] OP_PROG = 3'h2;
	localparam logic [2:0] OP_ERASE = 3'h3;
	localparam logic [2:0] OP_COPY = 3'h4;
	localparam logic [1:0] UC_WRITE = 2'h0;
	localparam logic [1:0] UC_READ = 2'h1;
	localparam logic [1:0] UC_GC = 2'h2;
	localparam logic [1:0] UC_INVAL = 2'h3;
	localparam logic [1:0] PU_WRITE = 2'h0;
	localparam logic [1:0] PU_FAIL = 2'h1;
	localparam logic [1:0] PU_GC = 2'h2;
	localparam logic [1:0] PU_WL = 2'h3;
	typedef enum logic [11:0] {
		S_SCAN = 12'h001, S_SCANW = 12'h002, S_IDLE = 12'h004,
		S_FILL = 12'h008, S_PICK = 12'h010, S_PROG = 12'h020,
		S_PROGW = 12'h040, S_MOVE = 12'h080, S_MOVEW = 12'h100,
		S_ERASE = 12'h200, S_ERW = 12'h400, S_RDW = 12'h800
	} fbm_state_t;
endpackage

// ===== fbm_manager.sv
`timescale 1ns/1ps
module fbm_manager #(
	parameter int NBLK = 4096,
	parameter int NPG = 32,
	parameter int WW = 17,
	parameter int WL_THR = 1000,
	localparam int BW = $clog2(NBLK),
	localparam int PW = $clog2(NPG)
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic [1:0] cmd_op_i,
	input wire logic [BW-1:0] cmd_blk_i,
	input wire logic [PW-1:0] cmd_pg_i,
	input wire logic wr_valid_i,
	input wire logic [7:0] wr_data_i,
	output logic wr_ready_o,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	input wire logic rd_ready_i,
	output logic done_o,
	output logic err_o,
	output logic [BW-1:0] res_blk_o,
	output logic [PW-1:0] res_pg_o,
	output logic fix_o,
	output logic [11:0] fix_pos_o,
	output logic uncorr_o,
	output logic scan_done_o,
	output logic fl_cmd_valid_o,
	input wire logic fl_cmd_ready_i,
	output logic [2:0] fl_op_o,
	output logic [BW-1:0] fl_blk_o,
	output logic [PW-1:0] fl_pg_o,
	output logic [BW-1:0] fl_dblk_o,
	output logic [9:0] fl_col_o,
	output logic [9:0] fl_len_o,
	output logic fl_wr_valid_o,
	output logic [7:0] fl_wr_data_o,
	input wire logic fl_wr_ready_i,
	input wire logic fl_rd_valid_i,
	input wire logic [7:0] fl_rd_data_i,
	output logic fl_rd_ready_o,
	input wire logic fl_done_i,
	input wire logic [7:0] fl_status_i
);
	// Running 24-bit line/column parity code over one 512-byte unit.
	function automatic logic [23:0] ecc_upd(input logic [23:0] e,
			input logic [8:0] ix, input logic [7:0] d);
		logic [23:0] r;
		r = e;
		for (int b = 0; b < 8; b++) begin
			for (int k = 0; k < 3; k++) begin
				if (b[k]) r[2*k+1] ^= d[b];
				else r[2*k] ^= d[b];
			end
		end
		for (int k = 0; k < 9; k++) begin
			if (ix[k]) r[2*k+7] ^= ^d;
			else r[2*k+6] ^= ^d;
		end
		return r;
	endfunction

	fbm_pkg::fbm_state_t st_r, st_nxt;
	logic [BW-1:0] ix_r, ix_nxt, src_r, src_nxt, dst_r, dst_nxt, best_r;
	logic [BW-1:0] best_nxt, act_r, act_nxt, cold_r, cold_nxt;
	logic [PW-1:0] pg_r, pg_nxt, skip_r, skip_nxt;
	logic [PW:0] apg_r, apg_nxt;
	logic [1:0] pu_r, pu_nxt;
	logic [9:0] cnt_r, cnt_nxt;
	logic [23:0] ecc_r, ecc_nxt, ecs_r, ecs_nxt, syn;
	logic [WW-1:0] bw_r, bw_nxt, mnw_r, mnw_nxt, mxw_r, mxw_nxt;
	logic bok_r, bok_nxt, aok_r, aok_nxt, gap_r, gap_nxt, cok_r, cok_nxt;
	logic [2:0] fop_r, fop_nxt;
	logic [9:0] fcol_r, fcol_nxt, flen_r, flen_nxt;
	logic wv_r, wv_nxt, dn_r, dn_nxt, er_r, er_nxt, fx_r, fx_nxt;
	logic uc_r, uc_nxt, sd_r, sd_nxt;
	logic [7:0] wd_r, wd_nxt;
	logic [11:0] fp_r, fp_nxt;
	logic bad_we, bad_v, free_we, free_v, wear_inc, pb_we;
	logic [BW-1:0] bad_ix, free_ix, vm_blk;
	logic [1:0] vm_op;
	logic [7:0] bufd [2];
	logic [1:0] bcnt_r, bcnt_nxt;
	logic b_push, b_pop, fdone, ffail, cand, better;
	logic bad_r [NBLK];
	logic free_r [NBLK];
	logic [WW-1:0] wear_r [NBLK];
	logic [NPG-1:0] vmap_r [NBLK];
	localparam int PG_BYTES_L = fbm_pkg::PG_BYTES;
	logic [7:0] pbuf [PG_BYTES_L];

	assign fdone = fl_done_i && fl_status_i[fbm_pkg::SR_RDY];
	assign ffail = fl_status_i[fbm_pkg::SR_FAIL];
	assign cand = !bad_r[ix_r] && free_r[ix_r];
	assign better = (pu_r == fbm_pkg::PU_WL) ? (wear_r[ix_r] > bw_r) :
		(wear_r[ix_r] < bw_r);
	assign syn = ecc_r ^ ecs_r;
	assign b_push = (st_r == fbm_pkg::S_RDW) && fl_rd_valid_i &&
		(cnt_r < 10'(fbm_pkg::PG_BYTES)) && (bcnt_r != 2'd2);
	assign b_pop = rd_valid_o && rd_ready_i;
	assign rd_valid_o = (bcnt_r != 2'd0);
	assign rd_data_o = bufd[0];
	// Wear leveling goes first in idle, so no command is taken then.
	assign cmd_ready_o = (st_r == fbm_pkg::S_IDLE) && !dn_r &&
		!(gap_r && cok_r);
	assign wr_ready_o = (st_r == fbm_pkg::S_FILL);
	// A request is offered only once the opcode register holds its operation,
	// so the flash never takes a stale opcode; column and length are reloaded only for reads and programs.
	assign fl_cmd_valid_o = (st_r == fbm_pkg::S_SCAN) ||
		(st_r == fbm_pkg::S_PROG && fop_r == fbm_pkg::OP_PROG) ||
		(st_r == fbm_pkg::S_ERASE && fop_r == fbm_pkg::OP_ERASE) ||
		(fop_r == fbm_pkg::OP_COPY && st_r == fbm_pkg::S_MOVE &&
		vmap_r[src_r][pg_r] && !(pu_r == fbm_pkg::PU_FAIL && pg_r == skip_r)) ||
		(fop_r == fbm_pkg::OP_READ && st_r == fbm_pkg::S_RDW && cnt_r == 10'h3FF);
	assign fl_rd_ready_o = (st_r == fbm_pkg::S_RDW) ?
		(cnt_r >= 10'(fbm_pkg::PG_BYTES) || bcnt_r != 2'd2) : 1'b1;
	assign fl_op_o = fop_r;
	assign fl_blk_o = (st_r == fbm_pkg::S_PROG || st_r == fbm_pkg::S_PROGW) ?
		dst_r : src_r;
	assign fl_dblk_o = dst_r;
	assign fl_pg_o = pg_r;
	assign fl_col_o = fcol_r;
	assign fl_len_o = flen_r;
	assign fl_wr_valid_o = wv_r;
	assign fl_wr_data_o = wd_r;
	assign done_o = dn_r;
	assign err_o = er_r;
	assign res_blk_o = dst_r;
	assign res_pg_o = pg_r;
	assign fix_o = fx_r;
	assign fix_pos_o = fp_r;
	assign uncorr_o = uc_r;
	assign scan_done_o = sd_r;

	always_comb begin
		bcnt_nxt = bcnt_r + 2'(b_push) - 2'(b_pop);
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bcnt_r <= 2'd0;
		end else begin
			bcnt_r <= bcnt_nxt;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (b_pop) bufd[0] <= bufd[1];
		if (b_push && (bcnt_r == 2'd0 || (bcnt_r == 2'd1 && b_pop)))
			bufd[0] <= fl_rd_data_i;
		else if (b_push) bufd[1] <= fl_rd_data_i;
		if (pb_we) pbuf[cnt_r[8:0]] <= wr_data_i;
	end

	always_comb begin
		st_nxt = st_r; ix_nxt = ix_r; src_nxt = src_r; dst_nxt = dst_r;
		best_nxt = best_r; act_nxt = act_r; cold_nxt = cold_r;
		pg_nxt = pg_r; skip_nxt = skip_r; apg_nxt = apg_r; pu_nxt = pu_r;
		cnt_nxt = cnt_r; ecc_nxt = ecc_r; ecs_nxt = ecs_r; bw_nxt = bw_r;
		mnw_nxt = mnw_r; mxw_nxt = mxw_r; bok_nxt = bok_r; aok_nxt = aok_r;
		gap_nxt = gap_r; cok_nxt = cok_r; fop_nxt = fop_r; fcol_nxt = fcol_r;
		flen_nxt = flen_r; wv_nxt = wv_r; wd_nxt = wd_r; fp_nxt = fp_r;
		sd_nxt = sd_r; dn_nxt = 1'b0; er_nxt = er_r; fx_nxt = 1'b0;
		uc_nxt = 1'b0;
		bad_we = 1'b0; bad_v = 1'b0; bad_ix = ix_r; free_we = 1'b0;
		free_v = 1'b0; free_ix = ix_r; wear_inc = 1'b0; pb_we = 1'b0;
		vm_op = 2'd0; vm_blk = dst_r;
		case (st_r)
		fbm_pkg::S_SCAN: begin
			fop_nxt = fbm_pkg::OP_READ;
			fcol_nxt = fbm_pkg::MARK_COL;
			flen_nxt = 10'd1;
			if (fl_cmd_ready_i) st_nxt = fbm_pkg::S_SCANW;
		end
		fbm_pkg::S_SCANW: begin
			if (fl_rd_valid_i) begin
				bad_we = 1'b1;
				bad_v = (fl_rd_data_i != fbm_pkg::ALL_ONES);
				free_we = 1'b1;
				free_v = (fl_rd_data_i == fbm_pkg::ALL_ONES);
			end
			if (fdone) begin
				ix_nxt = ix_r + 1'b1;
				src_nxt = ix_r + 1'b1;
				st_nxt = fbm_pkg::S_SCAN;
				if (ix_r == BW'(NBLK - 1)) begin
					sd_nxt = 1'b1;
					st_nxt = fbm_pkg::S_IDLE;
				end
			end
		end
		fbm_pkg::S_IDLE: begin
			er_nxt = 1'b0;
			if (gap_r && cok_r && !dn_r) begin
				gap_nxt = 1'b0;
				src_nxt = cold_r;
				pu_nxt = fbm_pkg::PU_WL;
				st_nxt = fbm_pkg::S_PICK;
				ix_nxt = '0; bok_nxt = 1'b0; cok_nxt = 1'b0;
			end else if (cmd_valid_i && cmd_ready_o) begin
				ix_nxt = '0; bok_nxt = 1'b0; cok_nxt = 1'b0; cnt_nxt = '0;
				ecc_nxt = '0; pg_nxt = cmd_pg_i; src_nxt = cmd_blk_i;
				case (cmd_op_i)
				fbm_pkg::UC_WRITE: st_nxt = fbm_pkg::S_FILL;
				fbm_pkg::UC_READ: begin
					fop_nxt = fbm_pkg::OP_READ;
					fcol_nxt = '0;
					flen_nxt = 10'(fbm_pkg::XFER_LEN);
					cnt_nxt = 10'h3FF;
					st_nxt = fbm_pkg::S_RDW;
				end
				fbm_pkg::UC_GC: begin
					pu_nxt = fbm_pkg::PU_GC;
					st_nxt = fbm_pkg::S_PICK;
				end
				default: begin
					vm_op = 2'd2;
					vm_blk = cmd_blk_i;
					dn_nxt = 1'b1;
				end
				endcase
			end
		end
		fbm_pkg::S_FILL: begin
			if (wr_valid_i) begin
				pb_we = 1'b1;
				ecc_nxt = ecc_upd(ecc_r, cnt_r[8:0], wr_data_i);
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == 10'(fbm_pkg::PG_BYTES - 1)) begin
					pu_nxt = fbm_pkg::PU_WRITE;
					if (aok_r && apg_r < (PW+1)'(NPG)) begin
						dst_nxt = act_r;
						pg_nxt = apg_r[PW-1:0];
						st_nxt = fbm_pkg::S_PROG;
					end else begin
						st_nxt = fbm_pkg::S_PICK;
					end
				end
			end
		end
		fbm_pkg::S_PICK: begin
			if (cand && (!bok_r || better)) begin
				best_nxt = ix_r; bw_nxt = wear_r[ix_r]; bok_nxt = 1'b1;
			end
			if (!bad_r[ix_r]) begin
				if (ix_r == '0 || wear_r[ix_r] < mnw_r) mnw_nxt = wear_r[ix_r];
				if (ix_r == '0 || wear_r[ix_r] > mxw_r) mxw_nxt = wear_r[ix_r];
				if (!free_r[ix_r] && (!cok_r || wear_r[ix_r] < wear_r[cold_r])) begin
					cold_nxt = ix_r; cok_nxt = 1'b1;
				end
			end
			ix_nxt = ix_r + 1'b1;
			if (ix_r == BW'(NBLK - 1)) begin
				gap_nxt = (mxw_nxt - mnw_nxt) >= WW'(WL_THR);
				if (!bok_nxt) begin
					er_nxt = 1'b1; dn_nxt = 1'b1; st_nxt = fbm_pkg::S_IDLE;
				end else begin
					dst_nxt = best_nxt;
					free_we = 1'b1; free_ix = best_nxt;
					if (pu_r == fbm_pkg::PU_WRITE || pu_r == fbm_pkg::PU_FAIL) begin
						act_nxt = best_nxt; aok_nxt = 1'b1;
						if (pu_r == fbm_pkg::PU_WRITE) pg_nxt = '0;
						st_nxt = fbm_pkg::S_PROG;
					end else begin
						pg_nxt = '0; apg_nxt = '0;
						fop_nxt = fbm_pkg::OP_COPY;
						st_nxt = fbm_pkg::S_MOVE;
					end
				end
			end
		end
		fbm_pkg::S_PROG: begin
			fop_nxt = fbm_pkg::OP_PROG;
			fcol_nxt = '0;
			flen_nxt = 10'(fbm_pkg::XFER_LEN);
			if (fl_cmd_valid_o && fl_cmd_ready_i) begin
				st_nxt = fbm_pkg::S_PROGW;
				wv_nxt = 1'b1; wd_nxt = pbuf[0]; cnt_nxt = 10'd1;
			end
		end
		fbm_pkg::S_PROGW: begin
			if (wv_r && fl_wr_ready_i) begin
				cnt_nxt = cnt_r + 1'b1;
				wv_nxt = (cnt_r != 10'(fbm_pkg::XFER_LEN));
				case (cnt_r)
				10'd512: wd_nxt = ecc_r[7:0];
				10'd513: wd_nxt = ecc_r[15:8];
				10'd514: wd_nxt = ecc_r[23:16];
				default: wd_nxt = pbuf[cnt_r[8:0]];
				endcase
			end
			if (fdone) begin
				wv_nxt = 1'b0;
				ix_nxt = '0; bok_nxt = 1'b0; cok_nxt = 1'b0;
				if (ffail) begin
					bad_we = 1'b1; bad_v = 1'b1; bad_ix = dst_r;
					if (pu_r != fbm_pkg::PU_FAIL) src_nxt = dst_r;
					skip_nxt = pg_r;
					pu_nxt = fbm_pkg::PU_FAIL;
					st_nxt = fbm_pkg::S_PICK;
				end else begin
					vm_op = 2'd1;
					apg_nxt = (PW+1)'(pg_r) + 1'b1;
					if (pu_r == fbm_pkg::PU_FAIL) begin
						pg_nxt = '0; fop_nxt = fbm_pkg::OP_COPY;
						st_nxt = fbm_pkg::S_MOVE;
					end else begin
						dn_nxt = 1'b1; st_nxt = fbm_pkg::S_IDLE;
					end
				end
			end
		end
		fbm_pkg::S_MOVE: begin
			if (fl_cmd_valid_o) begin
				if (fl_cmd_ready_i) st_nxt = fbm_pkg::S_MOVEW;
			end else if (pg_r == PW'(NPG - 1)) begin
				if (pu_r == fbm_pkg::PU_FAIL) begin
					pg_nxt = skip_r; dn_nxt = 1'b1; st_nxt = fbm_pkg::S_IDLE;
				end else begin
					act_nxt = dst_r; aok_nxt = 1'b1; st_nxt = fbm_pkg::S_ERASE;
				end
			end else begin
				pg_nxt = pg_r + 1'b1;
			end
		end
		fbm_pkg::S_MOVEW: begin
			if (fdone) begin
				if (ffail) er_nxt = 1'b1;
				else vm_op = 2'd1;
				if (pu_r != fbm_pkg::PU_FAIL) apg_nxt = (PW+1)'(pg_r) + 1'b1;
				st_nxt = fbm_pkg::S_MOVE;
				if (pg_r != PW'(NPG - 1)) pg_nxt = pg_r + 1'b1;
				else fop_nxt = '0;
			end
		end
		fbm_pkg::S_ERASE: begin
			fop_nxt = fbm_pkg::OP_ERASE;
			if (fl_cmd_valid_o && fl_cmd_ready_i) st_nxt = fbm_pkg::S_ERW;
		end
		fbm_pkg::S_ERW: begin
			if (fdone) begin
				wear_inc = 1'b1;
				vm_op = 2'd3; vm_blk = src_r;
				bad_we = ffail; bad_v = 1'b1; bad_ix = src_r;
				free_we = 1'b1; free_v = !ffail; free_ix = src_r;
				dn_nxt = 1'b1; st_nxt = fbm_pkg::S_IDLE;
			end
		end
		fbm_pkg::S_RDW: begin
			if (cnt_r == 10'h3FF) begin
				if (fl_cmd_ready_i) cnt_nxt = '0;
			end else if (fl_rd_valid_i && fl_rd_ready_o) begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r < 10'(fbm_pkg::PG_BYTES))
					ecc_nxt = ecc_upd(ecc_r, cnt_r[8:0], fl_rd_data_i);
				else
					ecs_nxt = {fl_rd_data_i, ecs_r[23:8]};
			end
			if (fdone && cnt_r != 10'h3FF) begin
				// Only the code decides; a read never retires the block.
				fx_nxt = (syn != '0) &&
					((syn[23:1] ^ syn[22:0]) & 23'h55_5555) == 23'h55_5555;
				uc_nxt = (syn != '0) && !fx_nxt && ($countones(syn) != 1);
				fp_nxt = {syn[23], syn[21], syn[19], syn[17], syn[15], syn[13],
					syn[11], syn[9], syn[7], syn[5], syn[3], syn[1]};
				er_nxt = uc_nxt; dn_nxt = 1'b1; dst_nxt = src_r;
				st_nxt = fbm_pkg::S_IDLE;
			end
		end
		default: st_nxt = fbm_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= fbm_pkg::S_SCAN; ix_r <= '0; src_r <= '0; dst_r <= '0;
			best_r <= '0; act_r <= '0; cold_r <= '0; pg_r <= '0; skip_r <= '0;
			apg_r <= '0; pu_r <= '0; cnt_r <= '0; ecc_r <= '0; ecs_r <= '0;
			bw_r <= '0; mnw_r <= '0; mxw_r <= '0; bok_r <= 1'b0; aok_r <= 1'b0;
			gap_r <= 1'b0; cok_r <= 1'b0; fop_r <= fbm_pkg::OP_READ;
			fcol_r <= fbm_pkg::MARK_COL; flen_r <= 10'd1;
			wv_r <= 1'b0; wd_r <= '0; fp_r <= '0; sd_r <= 1'b0;
			dn_r <= 1'b0; er_r <= 1'b0; fx_r <= 1'b0; uc_r <= 1'b0;
		end else begin
			st_r <= st_nxt; ix_r <= ix_nxt; src_r <= src_nxt; dst_r <= dst_nxt;
			best_r <= best_nxt; act_r <= act_nxt; cold_r <= cold_nxt;
			pg_r <= pg_nxt; skip_r <= skip_nxt; apg_r <= apg_nxt; pu_r <= pu_nxt;
			cnt_r <= cnt_nxt; ecc_r <= ecc_nxt; ecs_r <= ecs_nxt; bw_r <= bw_nxt;
			mnw_r <= mnw_nxt; mxw_r <= mxw_nxt; bok_r <= bok_nxt;
			aok_r <= aok_nxt; gap_r <= gap_nxt; cok_r <= cok_nxt;
			fop_r <= fop_nxt; fcol_r <= fcol_nxt; flen_r <= flen_nxt;
			wv_r <= wv_nxt; wd_r <= wd_nxt; fp_r <= fp_nxt; sd_r <= sd_nxt;
			dn_r <= dn_nxt; er_r <= er_nxt; fx_r <= fx_nxt; uc_r <= uc_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < NBLK; i++) begin
				bad_r[i] <= 1'b1; free_r[i] <= 1'b0;
				wear_r[i] <= '0; vmap_r[i] <= '0;
			end
		end else begin
			if (bad_we) bad_r[bad_ix] <= bad_v;
			if (free_we) free_r[free_ix] <= free_v;
			if (wear_inc) wear_r[src_r] <= wear_r[src_r] + 1'b1;
			case (vm_op)
			2'd1: vmap_r[vm_blk][pg_r] <= 1'b1;
			2'd2: vmap_r[vm_blk][pg_nxt] <= 1'b0;
			2'd3: vmap_r[vm_blk] <= '0;
			default: ;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	a_erase_after_scan: assert property (
		fl_cmd_valid_o && fl_op_o == fbm_pkg::OP_ERASE |-> sd_r)
		else $error("erase issued before marker scan finished");
	a_scan_marker_col: assert property (
		fl_cmd_valid_o && st_r == fbm_pkg::S_SCAN |->
		fl_col_o == fbm_pkg::MARK_COL && fl_op_o == fbm_pkg::OP_READ)
		else $error("marker read at wrong column");
	a_bad_from_marker: assert property (
		st_r == fbm_pkg::S_SCANW && fl_rd_valid_i |=>
		bad_r[$past(ix_r)] == ($past(fl_rd_data_i) != 8'hFF))
		else $error("bad table does not follow marker");
	a_fail_retires: assert property (
		st_r == fbm_pkg::S_PROGW && fdone && ffail |=>
		bad_r[$past(dst_r)] && st_r == fbm_pkg::S_PICK)
		else $error("failed block not retired");
	a_fail_rewrite: assert property (
		st_r == fbm_pkg::S_PICK && pu_r == fbm_pkg::PU_FAIL &&
		st_nxt == fbm_pkg::S_PROG |=> pg_r == skip_r)
		else $error("failed page not rewritten at same page");
	a_read_no_retire: assert property (
		st_r == fbm_pkg::S_RDW |-> !bad_we)
		else $error("read retired a block");
	a_fix_with_done: assert property (
		fx_r |-> dn_r && !uc_r && $past(st_r) == fbm_pkg::S_RDW)
		else $error("correction report outside read completion");
	a_prog_length: assert property (
		fl_cmd_valid_o && fl_op_o == fbm_pkg::OP_PROG |-> fl_len_o == 10'd515)
		else $error("program length omits code bytes");
	a_gc_erase_src: assert property (
		st_r == fbm_pkg::S_ERASE |-> fl_blk_o == src_r && !fl_wr_valid_o)
		else $error("erase aimed at wrong block");

	c_scan_done: cover property (st_r == fbm_pkg::S_SCANW ##1 sd_r);
	c_prog_fail: cover property (st_r == fbm_pkg::S_PROGW && fdone && ffail);
	c_read_fix: cover property (fx_r);
	c_gc_erase: cover property (st_r == fbm_pkg::S_ERW && fdone);
endmodule // fbm_manager

// ===== fbm_flash_model.sv
`timescale 1ns/1ps
module fbm_flash_model #(
	parameter int BAD_BLK = 2
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic [2:0] op_i,
	input wire logic [2:0] blk_i,
	input wire logic [1:0] pg_i,
	input wire logic [2:0] dblk_i,
	input wire logic [9:0] col_i,
	input wire logic [9:0] len_i,
	input wire logic wr_valid_i,
	input wire logic [7:0] wr_data_i,
	output logic wr_ready_o,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	input wire logic rd_ready_i,
	output logic done_o,
	output logic [7:0] status_o,
	input wire logic fail_en_i,
	input wire logic [2:0] fail_blk_i,
	input wire logic [1:0] flip_i,
	input wire logic [3:0] lat_i,
	output int erase_cnt_o,
	output logic bad_erased_o
);
	logic [7:0] mem [int];
	logic [2:0] op, b, d;
	logic [1:0] p;
	logic f;
	int c, n, k;
	function automatic int ad(input logic [2:0] bb, input logic [1:0] pp,
		input int cc);
		return (int'(bb) * 4 + int'(pp)) * 1024 + cc;
	endfunction
	// Unwritten locations read as erased.
	function automatic logic [7:0] rd(input int a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction
	initial begin
		cmd_ready_o = 1'b0;
		wr_ready_o = 1'b0;
		rd_valid_o = 1'b0;
		rd_data_o = 8'h00;
		done_o = 1'b0;
		status_o = 8'h00;
		erase_cnt_o = 0;
		bad_erased_o = 1'b0;
		mem[ad(BAD_BLK, 2'h0, 517)] = 8'h00;
		forever begin
			@(posedge clk_sys_i);
			done_o <= 1'b0;
			cmd_ready_o <= nrst_i;
			if (nrst_i && cmd_valid_i && cmd_ready_o) begin
				cmd_ready_o <= 1'b0;
				status_o <= 8'h00;
				op = op_i;
				b = blk_i;
				p = pg_i;
				d = dblk_i;
				c = int'(col_i);
				n = int'(len_i);
				f = fail_en_i && blk_i == fail_blk_i && op_i == fbm_pkg::OP_PROG;
				repeat (lat_i) @(posedge clk_sys_i);
				for (k = 0; k < n && op == fbm_pkg::OP_READ; k++) begin
					rd_valid_o <= 1'b1;
					rd_data_o <= rd(ad(b, p, c + k)) ^ {4'h0, flip_i == 2'h2 &&
						c + k == 9, 2'h0, flip_i != 2'h0 && c + k == 5};
					do @(posedge clk_sys_i); while (!rd_ready_i);
				end
				rd_valid_o <= 1'b0;
				rd_data_o <= ~rd_data_o;
				if (op == fbm_pkg::OP_PROG) begin
					wr_ready_o <= 1'b1;
					k = 0;
					while (k < n) begin
						@(posedge clk_sys_i);
						if (wr_valid_i) begin
							mem[ad(b, p, c + k)] = wr_data_i;
							k++;
						end
					end
					wr_ready_o <= 1'b0;
				end
				if (op == fbm_pkg::OP_ERASE) begin
					erase_cnt_o <= erase_cnt_o + 1;
					if (b == BAD_BLK) bad_erased_o <= 1'b1;
					for (k = 0; k < 4096; k++)
						if (mem.exists(ad(b, 2'h0, k))) mem.delete(ad(b, 2'h0, k));
				end
				for (k = 0; k < 528 && op == fbm_pkg::OP_COPY; k++)
					mem[ad(d, p, k)] = rd(ad(b, p, k));
				status_o <= {1'b0, 1'b1, 5'h00, f};
				done_o <= 1'b1;
			end
		end
	end
endmodule // fbm_flash_model

// ===== test_fbm_manager.sv
`timescale 1ns/1ps
module test_fbm_manager;
	logic clk_sys_i, nrst_i, cmd_valid_i, cmd_ready_o, wr_valid_i, wr_ready_o;
	logic rd_valid_o, rd_ready_i, done_o, err_o, fix_o, uncorr_o, scan_done_o;
	logic fl_cmd_valid_o, fl_cmd_ready_i, fl_wr_valid_o, fl_wr_ready_i;
	logic fl_rd_valid_i, fl_rd_ready_o, fl_done_i, fail_en, bad_erased;
	logic [1:0] cmd_op_i, cmd_pg_i, res_pg_o, fl_pg_o, flip;
	logic [2:0] cmd_blk_i, res_blk_o, fl_op_o, fl_blk_o, fl_dblk_o, fail_blk;
	logic [7:0] wr_data_i, rd_data_o, fl_wr_data_o, fl_rd_data_i, fl_status_i;
	logic [9:0] fl_col_o, fl_len_o;
	logic [11:0] fix_pos_o, r_pos;
	logic [3:0] lat;
	logic r_err, r_fix, r_unc;
	logic [2:0] r_blk, w_blk;
	logic [1:0] r_pg;
	int erase_cnt, e0;
	int errors = 0;
	int num_checks = 0;
	int cyc = 0;
	fbm_manager #(.NBLK(8), .NPG(4), .WL_THR(2)) i_dut (.clk_sys_i, .nrst_i,
		.cmd_valid_i, .cmd_ready_o, .cmd_op_i, .cmd_blk_i, .cmd_pg_i,
		.wr_valid_i, .wr_data_i, .wr_ready_o, .rd_valid_o, .rd_data_o,
		.rd_ready_i, .done_o, .err_o, .res_blk_o, .res_pg_o, .fix_o,
		.fix_pos_o, .uncorr_o, .scan_done_o, .fl_cmd_valid_o, .fl_cmd_ready_i,
		.fl_op_o, .fl_blk_o, .fl_pg_o, .fl_dblk_o, .fl_col_o, .fl_len_o,
		.fl_wr_valid_o, .fl_wr_data_o, .fl_wr_ready_i, .fl_rd_valid_i,
		.fl_rd_data_i, .fl_rd_ready_o, .fl_done_i, .fl_status_i);
	fbm_flash_model i_mem (.clk_sys_i, .nrst_i, .cmd_valid_i(fl_cmd_valid_o),
		.cmd_ready_o(fl_cmd_ready_i), .op_i(fl_op_o), .blk_i(fl_blk_o),
		.pg_i(fl_pg_o), .dblk_i(fl_dblk_o), .col_i(fl_col_o),
		.len_i(fl_len_o), .wr_valid_i(fl_wr_valid_o),
		.wr_data_i(fl_wr_data_o), .wr_ready_o(fl_wr_ready_i),
		.rd_valid_o(fl_rd_valid_i), .rd_data_o(fl_rd_data_i),
		.rd_ready_i(fl_rd_ready_o), .done_o(fl_done_i),
		.status_o(fl_status_i), .fail_en_i(fail_en), .fail_blk_i(fail_blk),
		.flip_i(flip), .lat_i(lat), .erase_cnt_o(erase_cnt),
		.bad_erased_o(bad_erased));
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	task automatic report_and_stop();
		$display("errors %0d checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			errors++;
			report_and_stop();
		end
	end
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// One user command; write data is streamed without gaps, read data with rd_ready_i low on alternate cycles.
	task automatic run(input logic [1:0] op, input logic [2:0] b,
		input logic [1:0] p, input logic [7:0] s);
		int k, n;
		logic got;
		logic [7:0] e;
		k = 0;
		n = 0;
		got = 1'b0;
		@(negedge clk_sys_i);
		cmd_valid_i = 1'b1;
		cmd_op_i = op;
		cmd_blk_i = b;
		cmd_pg_i = p;
		do @(posedge clk_sys_i); while (cmd_ready_o !== 1'b1);
		while ((!got || rd_valid_o === 1'b1) && n < 20000) begin
			@(negedge clk_sys_i);
			cmd_valid_i = 1'b0;
			wr_valid_i = op == fbm_pkg::UC_WRITE && k < 512;
			wr_data_i = k[7:0] ^ s;
			rd_ready_i = n[0];
			@(posedge clk_sys_i);
			n++;
			if (wr_valid_i && wr_ready_o === 1'b1) k++;
			if (rd_valid_o === 1'b1 && rd_ready_i) begin
				e = (k[7:0] ^ s) ^ {4'h0, flip == 2'h2 && k == 9, 2'h0,
					flip != 2'h0 && k == 5};
				check(rd_data_o, e);
				k++;
			end
			if (done_o === 1'b1) begin
				got = 1'b1;
				{r_err, r_fix, r_unc, r_pos} = {err_o, fix_o, uncorr_o, fix_pos_o};
				{r_blk, r_pg} = {res_blk_o, res_pg_o};
			end
		end
		wr_valid_i = 1'b0;
		check(got, 1'b1);
		if (op < 2'h2) check(k, 512);
	endtask
	task automatic t_scan();
		int n;
		n = 0;
		while (scan_done_o !== 1'b1 && n < 2000) begin
			check(cmd_ready_o, 1'b0);
			@(negedge clk_sys_i);
			n++;
		end
		check(scan_done_o, 1'b1);
		check(erase_cnt, 0);
	endtask
	task automatic t_write_read();
		lat = 4'h3;
		run(fbm_pkg::UC_WRITE, 3'h0, 2'h0, 8'h11);
		w_blk = r_blk;
		check(r_err, 1'b0);
		check(r_blk == 3'h2, 1'b0);
		check(r_pg, 2'h0);
		run(fbm_pkg::UC_WRITE, 3'h0, 2'h0, 8'h22);
		check({r_blk, r_pg}, {w_blk, 2'h1});
		run(fbm_pkg::UC_READ, w_blk, 2'h0, 8'h11);
		check({r_err, r_fix, r_unc}, 3'h0);
	endtask
	task automatic t_ecc();
		flip = 2'h1;
		run(fbm_pkg::UC_READ, w_blk, 2'h1, 8'h22);
		check({r_err, r_fix, r_unc}, 3'h2);
		check(r_pos, 12'h028);
		flip = 2'h2;
		run(fbm_pkg::UC_READ, w_blk, 2'h1, 8'h22);
		check({r_fix, r_unc}, 2'h1);
		check(r_err, 1'b1);
		flip = 2'h0;
		run(fbm_pkg::UC_READ, w_blk, 2'h1, 8'h22);
		check({r_err, r_fix, r_unc}, 3'h0);
	endtask
	task automatic t_prog_fail();
		fail_en = 1'b1;
		fail_blk = w_blk;
		lat = 4'h0;
		run(fbm_pkg::UC_WRITE, 3'h0, 2'h0, 8'h33);
		fail_en = 1'b0;
		check(r_err, 1'b0);
		check(r_blk == w_blk, 1'b0);
		check(r_pg, 2'h2);
		w_blk = r_blk;
		run(fbm_pkg::UC_READ, w_blk, 2'h0, 8'h11);
		run(fbm_pkg::UC_READ, w_blk, 2'h2, 8'h33);
		run(fbm_pkg::UC_WRITE, 3'h0, 2'h0, 8'h44);
		check(r_blk == fail_blk, 1'b0);
	endtask
	task automatic t_gc();
		run(fbm_pkg::UC_INVAL, w_blk, 2'h0, 8'h00);
		check(r_err, 1'b0);
		e0 = erase_cnt;
		run(fbm_pkg::UC_GC, w_blk, 2'h0, 8'h00);
		check(r_err, 1'b0);
		check(erase_cnt > e0, 1'b1);
		check(bad_erased, 1'b0);
	endtask
	initial begin
		nrst_i = 1'b0;
		cmd_valid_i = 1'b0;
		cmd_op_i = 2'h0;
		cmd_blk_i = 3'h0;
		cmd_pg_i = 2'h0;
		wr_valid_i = 1'b0;
		wr_data_i = 8'h00;
		rd_ready_i = 1'b0;
		fail_en = 1'b0;
		fail_blk = 3'h0;
		flip = 2'h0;
		lat = 4'h0;
		repeat (3) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		t_scan();
		t_write_read();
		t_ecc();
		t_prog_fail();
		t_gc();
		report_and_stop();
	end
endmodule // test_fbm_manager
